// file: design/rpb_bank.v
/*
 Receiver property bank: interrupt source enables, audio output format,
 audio output rate, reference frequency and reference divider, the
 status flags they gate, the shared interrupt pin and the reference
 prescaler. Assumes a command engine on the same clock drives the
 register port, the power state and the status events; only the
 external reference arrives from outside the clock domain.
*/
// Operation
// RL1: Only cts, fault, signal quality, radio data, seek/tune flags drive interrupt.
// RL2: A source sets its status flag before its interrupt is raised.
// RL3: After each property access, set clear-to-send and interrupt if enabled.
// RL4: Bit 7 of enables loads the power-up value and is writable.
// RL5: Controller accesses properties only while powered up.
// RL6: Repeat bits 11, 10, 8 allow interrupts while the flag is set.
// RL7: Enable bits 7, 6, 3, 2, 0 let each flag raise the interrupt.
// RL8: Format bit 7 picks rising or falling bit clock edge.
// RL9: Bits 6:3 pick I2S, left-justified, MSB at second or first clock.
// RL10: Format bit 2 forces mono, else threshold blend.
// RL11: Bits 1:0 give 16, 20, 24 or 8 bits per sample.
// RL12: Zero sample rate disables audio out; legal nonzero rate enables it.
// RL13: Controller supplies bit clock and frame sync before enabling output.
// RL14: Reference frequency takes 31130 to 34406 Hz, or 0 disabling correction.
// RL15: Internal reference is external input divided by the prescaler.
// RL16: External reference up to 40 MHz, gaps for small prescaler values.
// RL17: External reference valid around tune and seek commands.
// RL18: External reference stays valid while frequency correction is used.
// RL19: Reference frequency resets to 32768 Hz.
// RL20: Prescaler accepts integer values 1 to 4095.
// RL21: Interrupt pin holds from an enabled flag until status is serviced.
`timescale 1ns/1ps
`include "rpb_consts.vh"
module rpb_bank #(
    parameter AW = 16,
    parameter DW = 16,
    parameter DIVW = 12
) (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [AW-1:0] reg_addr,
    input wire [DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [DW-1:0] reg_rdata_ff,
    // Power state from the command engine
    input wire powered_up,
    input wire pwrup_cts_irq_en,
    // Status events and service
    input wire fault_evt,
    input wire signal_quality_evt,
    input wire radio_data_evt,
    input wire seek_tune_evt,
    input wire status_ack,
    // Status and interrupt
    output wire clear_to_send_flag,
    output wire fault_flag,
    output wire signal_quality_flag,
    output wire radio_data_flag,
    output wire seek_tune_done_flag,
    output reg shared_interrupt_pin_ff,
    // Audio output configuration
    output reg out_edge_select_ff,
    output reg [3:0] out_framing_mode_ff,
    output reg force_single_channel_ff,
    output reg [4:0] out_word_bits_ff,
    output reg [DW-1:0] out_sample_rate_ff,
    output reg audio_out_en_ff,
    // Reference clock
    input wire ext_reference,
    output reg [DW-1:0] reference_freq_value_ff,
    output reg auto_freq_correction_ff,
    output reg internal_reference_ff
);
    // Property storage
    reg [DW-1:0] ien_ff;
    reg [DW-1:0] fmt_ff;
    reg [DIVW-1:0] reference_divider_value_ff;
    reg [DW-1:0] nxt_ien;
    reg [DW-1:0] nxt_fmt;
    reg [DW-1:0] nxt_rate;
    reg [DW-1:0] nxt_ref;
    reg [DIVW-1:0] nxt_div;
    reg [DW-1:0] nxt_rdata;
    reg nxt_bad;

    // Access tracking
    reg pwr_prev_ff;
    reg cts_set_ff;
    wire access;
    wire pwr_rise;
    wire cts_set;
    wire err_evt;

    // Per-source requests
    wire cts_req;
    wire err_req;
    wire sq_req;
    wire rd_req;
    wire st_req;
    wire any_req;

    // Reference prescaler
    reg ref_sync1_ff;
    reg ref_sync2_ff;
    reg ref_prev_ff;
    reg [DIVW-1:0] ref_cnt_ff;
    reg [DIVW-1:0] nxt_ref_cnt;
    reg nxt_tick;
    wire ref_rise;

    assign access = reg_wr | reg_rd;
    assign pwr_rise = powered_up & ~pwr_prev_ff;

    // Clear-to-send rises one cycle after the last of a run of accesses
    // and on power-up; a back-to-back access keeps it low
    assign cts_set = (cts_set_ff & ~access) | pwr_rise; // RL3
    assign err_evt = nxt_bad | fault_evt;

    // Decode, range checks and read mux
    always @* begin
        nxt_ien = ien_ff;
        nxt_fmt = fmt_ff;
        nxt_rate = out_sample_rate_ff;
        nxt_ref = reference_freq_value_ff;
        nxt_div = reference_divider_value_ff;
        nxt_rdata = {DW{1'b0}};
        nxt_bad = 1'b0;
        // Power-up loads the clear-to-send enable from the command argument
        if (pwr_rise) begin
            nxt_ien[`RPB_IEN_CTS] = pwrup_cts_irq_en; // RL4
        end
        // Accesses outside the powered state are refused and flagged
        if (access && !powered_up) begin
            nxt_bad = 1'b1; // RL5
        end else if (access) begin
            case (reg_addr)
                `RPB_ADDR_IEN: begin
                    nxt_rdata = ien_ff & `RPB_MASK_IEN; // RL1
                    if (reg_wr) begin
                        nxt_ien = reg_wdata & `RPB_MASK_IEN; // RL4
                    end
                end
                `RPB_ADDR_FMT: begin
                    nxt_rdata = fmt_ff;
                    if (reg_wr) begin
                        // Only the four framing codes are taken
                        case (reg_wdata[`RPB_FMT_MODE_HI:`RPB_FMT_MODE_LO])
                            `RPB_MODE_I2S,
                            `RPB_MODE_LEFT,
                            `RPB_MODE_MSB2,
                            `RPB_MODE_MSB1: nxt_fmt = reg_wdata & `RPB_MASK_FMT; // RL9
                            default: nxt_bad = 1'b1;
                        endcase
                    end
                end
                `RPB_ADDR_RATE: begin
                    nxt_rdata = out_sample_rate_ff;
                    if (reg_wr) begin
                        if (reg_wdata == {DW{1'b0}} ||
                            (reg_wdata >= `RPB_RATE_MIN && reg_wdata <= `RPB_RATE_MAX)) begin
                            nxt_rate = reg_wdata; // RL12
                        end else begin
                            nxt_bad = 1'b1;
                        end
                    end
                end
                `RPB_ADDR_REF: begin
                    nxt_rdata = reference_freq_value_ff;
                    if (reg_wr) begin
                        if (reg_wdata == {DW{1'b0}} ||
                            (reg_wdata >= `RPB_REF_MIN && reg_wdata <= `RPB_REF_MAX)) begin
                            nxt_ref = reg_wdata; // RL14
                        end else begin
                            nxt_bad = 1'b1;
                        end
                    end
                end
                `RPB_ADDR_DIV: begin
                    nxt_rdata = {{(DW-DIVW){1'b0}}, reference_divider_value_ff};
                    if (reg_wr) begin
                        // Zero is refused; the prescaler compare would treat it as one
                        if (reg_wdata[DIVW-1:0] >= `RPB_DIV_MIN) begin
                            nxt_div = reg_wdata[DIVW-1:0]; // RL20
                        end else begin
                            nxt_bad = 1'b1;
                        end
                    end
                end
                default: nxt_bad = 1'b1;
            endcase
        end
    end

    // Property registers and read data
    always @(posedge clk) begin
        if (rst) begin
            ien_ff <= `RPB_RST_IEN;
            fmt_ff <= `RPB_RST_FMT;
            out_sample_rate_ff <= `RPB_RST_RATE;
            reference_freq_value_ff <= `RPB_RST_REF; // RL19
            reference_divider_value_ff <= `RPB_RST_DIV;
            reg_rdata_ff <= {DW{1'b0}};
            pwr_prev_ff <= 1'b0;
            cts_set_ff <= 1'b0;
        end else if (ce) begin
            ien_ff <= nxt_ien;
            fmt_ff <= nxt_fmt;
            out_sample_rate_ff <= nxt_rate;
            reference_freq_value_ff <= nxt_ref;
            reference_divider_value_ff <= nxt_div;
            reg_rdata_ff <= reg_rd ? nxt_rdata : {DW{1'b0}}; // Writes leave read data at zero
            pwr_prev_ff <= powered_up;
            cts_set_ff <= access; // RL3
        end
    end

    // Decoded audio and reference outputs, each from its own flop
    always @(posedge clk) begin
        if (rst) begin
            out_edge_select_ff <= 1'b0;
            out_framing_mode_ff <= `RPB_MODE_I2S;
            force_single_channel_ff <= 1'b0;
            out_word_bits_ff <= `RPB_BITS_16;
            audio_out_en_ff <= 1'b0;
            auto_freq_correction_ff <= 1'b1;
        end else if (ce) begin
            out_edge_select_ff <= nxt_fmt[`RPB_FMT_EDGE]; // RL8
            out_framing_mode_ff <= nxt_fmt[`RPB_FMT_MODE_HI:`RPB_FMT_MODE_LO]; // RL9
            force_single_channel_ff <= nxt_fmt[`RPB_FMT_MONO]; // RL10
            case (nxt_fmt[`RPB_FMT_PREC_HI:`RPB_FMT_PREC_LO])
                `RPB_PREC_16: out_word_bits_ff <= `RPB_BITS_16; // RL11
                `RPB_PREC_20: out_word_bits_ff <= `RPB_BITS_20; // RL11
                `RPB_PREC_24: out_word_bits_ff <= `RPB_BITS_24; // RL11
                default: out_word_bits_ff <= `RPB_BITS_8; // RL11
            endcase
            // Enabling output assumes bit clock and frame sync already run
            audio_out_en_ff <= (nxt_rate != {DW{1'b0}}); // RL12 RL13
            auto_freq_correction_ff <= (nxt_ref != {DW{1'b0}}); // RL14
        end
    end

    // Status sources; only the five status bits can reach the pin
    rpb_src u_cts (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .evt(cts_set),
        .clr(access),
        .en(ien_ff[`RPB_IEN_CTS]),
        .rep(1'b0),
        .flag_ff(clear_to_send_flag),
        .req_ff(cts_req)
    ); // RL1 RL2 RL3 RL7
    rpb_src u_err (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .evt(err_evt),
        .clr(status_ack),
        .en(ien_ff[`RPB_IEN_ERR]),
        .rep(1'b0),
        .flag_ff(fault_flag),
        .req_ff(err_req)
    ); // RL2 RL7
    rpb_src u_sq (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .evt(signal_quality_evt),
        .clr(status_ack),
        .en(ien_ff[`RPB_IEN_SQ]),
        .rep(ien_ff[`RPB_IEN_SQ_REP]),
        .flag_ff(signal_quality_flag),
        .req_ff(sq_req)
    ); // RL6 RL7
    rpb_src u_rd (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .evt(radio_data_evt),
        .clr(status_ack),
        .en(ien_ff[`RPB_IEN_RD]),
        .rep(ien_ff[`RPB_IEN_RD_REP]),
        .flag_ff(radio_data_flag),
        .req_ff(rd_req)
    ); // RL6 RL7
    rpb_src u_st (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .evt(seek_tune_evt),
        .clr(status_ack),
        .en(ien_ff[`RPB_IEN_ST]),
        .rep(ien_ff[`RPB_IEN_ST_REP]),
        .flag_ff(seek_tune_done_flag),
        .req_ff(st_req)
    ); // RL6 RL7

    assign any_req = cts_req | err_req | sq_req | rd_req | st_req;

    // Pin holds until serviced; a new request in the ack cycle wins
    always @(posedge clk) begin
        if (rst) begin
            shared_interrupt_pin_ff <= 1'b0;
        end else if (ce) begin
            if (any_req) begin
                shared_interrupt_pin_ff <= 1'b1; // RL21
            end else if (status_ack) begin
                shared_interrupt_pin_ff <= 1'b0; // RL21
            end
        end
    end

    // External reference synchroniser and edge detector
    always @(posedge clk) begin
        if (rst) begin
            ref_sync1_ff <= 1'b0;
            ref_sync2_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
        end else if (ce) begin
            ref_sync1_ff <= ext_reference;
            ref_sync2_ff <= ref_sync1_ff;
            ref_prev_ff <= ref_sync2_ff;
        end
    end

    assign ref_rise = ref_sync2_ff & ~ref_prev_ff;

    // Prescaler: one tick per divider-count rising edges.
    // Usable only while the reference is well below half the clock rate.
    always @* begin
        nxt_ref_cnt = ref_cnt_ff;
        nxt_tick = 1'b0;
        if (ref_rise) begin
            if (ref_cnt_ff + `RPB_DIV_MIN >= reference_divider_value_ff) begin
                nxt_ref_cnt = {DIVW{1'b0}};
                nxt_tick = 1'b1; // RL15
            end else begin
                nxt_ref_cnt = ref_cnt_ff + `RPB_DIV_MIN;
            end
        end
    end

    // Prescaler state; a stopped reference simply holds the count
    always @(posedge clk) begin
        if (rst) begin
            ref_cnt_ff <= {DIVW{1'b0}};
            internal_reference_ff <= 1'b0;
        end else if (ce) begin
            ref_cnt_ff <= nxt_ref_cnt;
            internal_reference_ff <= nxt_tick; // RL15
        end
    end
endmodule

// file: design/rpb_src.v
/*
 One status source: a sticky flag plus a registered interrupt request.
 Assumes event and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module rpb_src (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Source control
    input wire evt,
    input wire clr,
    input wire en,
    input wire rep,
    // Flag and request
    output reg flag_ff,
    output reg req_ff
);
    reg nxt_flag;
    reg nxt_req;

    // Set beats clear so an event in the clearing cycle is kept
    always @* begin
        nxt_flag = flag_ff;
        if (evt) begin
            nxt_flag = 1'b1;
        end else if (clr) begin
            nxt_flag = 1'b0;
        end
        // Request registers in the same cycle as the flag
        nxt_req = evt & en & (~flag_ff | rep);
    end

    // Flag and request storage
    always @(posedge clk) begin
        if (rst) begin
            flag_ff <= 1'b0;
            req_ff <= 1'b0;
        end else if (ce) begin
            flag_ff <= nxt_flag;
            req_ff <= nxt_req;
        end
    end
endmodule

// file: pkg/rpb_consts.vh
/*
 Constants of the receiver property bank: property offsets, field
 positions, writable masks, reset values and legal value ranges.
 Assumes inclusion by the property bank design and its test bench only.
*/
`ifndef RPB_CONSTS_VH
`define RPB_CONSTS_VH

// Property offsets on the register port
`define RPB_ADDR_IEN 16'h0001
`define RPB_ADDR_FMT 16'h0102
`define RPB_ADDR_RATE 16'h0104
`define RPB_ADDR_REF 16'h0201
`define RPB_ADDR_DIV 16'h0202

// Writable bits; reserved bits read as zero
`define RPB_MASK_IEN 16'h0dcd
`define RPB_MASK_FMT 16'h00ff
`define RPB_MASK_DIV 16'h0fff

// Reset values
`define RPB_RST_IEN 16'h0000
`define RPB_RST_FMT 16'h0000
`define RPB_RST_RATE 16'h0000
`define RPB_RST_REF 16'h8000
`define RPB_RST_DIV 12'h001

// Interrupt source enable layout
`define RPB_IEN_SQ_REP 11
`define RPB_IEN_RD_REP 10
`define RPB_IEN_ST_REP 8
`define RPB_IEN_CTS 7
`define RPB_IEN_ERR 6
`define RPB_IEN_SQ 3
`define RPB_IEN_RD 2
`define RPB_IEN_ST 0

// Status byte layout
`define RPB_ST_CTS 7
`define RPB_ST_ERR 6
`define RPB_ST_SQ 3
`define RPB_ST_RD 2
`define RPB_ST_ST 0

// Audio format layout
`define RPB_FMT_EDGE 7
`define RPB_FMT_MODE_HI 6
`define RPB_FMT_MODE_LO 3
`define RPB_FMT_MONO 2
`define RPB_FMT_PREC_HI 1
`define RPB_FMT_PREC_LO 0

// Framing codes
`define RPB_MODE_I2S 4'h0
`define RPB_MODE_LEFT 4'h6
`define RPB_MODE_MSB2 4'h8
`define RPB_MODE_MSB1 4'hc

// Precision codes and word lengths
`define RPB_PREC_16 2'h0
`define RPB_PREC_20 2'h1
`define RPB_PREC_24 2'h2
`define RPB_BITS_16 5'h10
`define RPB_BITS_20 5'h14
`define RPB_BITS_24 5'h18
`define RPB_BITS_8 5'h08

// Legal ranges
`define RPB_RATE_MIN 16'h7d00
`define RPB_RATE_MAX 16'hbb80
`define RPB_REF_MIN 16'h799a
`define RPB_REF_MAX 16'h8666
`define RPB_DIV_MIN 12'h001

`endif

// file: verification/rpb_bank_asserts.sv
/* Port checker for the receiver property bank.
 Assumes binding to rpb_bank, one clock, synchronous reset. */
`timescale 1ns/1ps
module rpb_bank_asserts (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // Register port
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_ff,
    input wire powered_up,
    // Events and service
    input wire seek_tune_evt,
    input wire status_ack,
    // Flags and pin
    input wire clear_to_send_flag,
    input wire fault_flag,
    input wire signal_quality_flag,
    input wire radio_data_flag,
    input wire seek_tune_done_flag,
    input wire shared_interrupt_pin_ff,
    // Reference
    input wire [15:0] reference_freq_value_ff,
    input wire auto_freq_correction_ff
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Helper terms
    wire any_flag = clear_to_send_flag | fault_flag | signal_quality_flag | radio_data_flag | seek_tune_done_flag;
    wire acc = ce & powered_up & (reg_wr | reg_rd);
    wire ref_ok = (reg_wdata == 16'h0000) || (reg_wdata >= 16'h799a && reg_wdata <= 16'h8666);

    chk_pin_after_flag: assert property ($rose(shared_interrupt_pin_ff) |-> $past(any_flag))
        else $error("pin rose with no flag");
    chk_pin_held: assert property (shared_interrupt_pin_ff && !status_ack |=> shared_interrupt_pin_ff)
        else $error("pin dropped unserviced");
    chk_cts_drop: assert property (acc |=> !clear_to_send_flag)
        else $error("cts stayed set on access");
    chk_cts_back: assert property (acc ##1 !(reg_wr || reg_rd) |=> clear_to_send_flag)
        else $error("cts not back after access");
    chk_stc_flag: assert property (ce && seek_tune_evt |=> seek_tune_done_flag)
        else $error("seek flag not set");
    chk_rdata_idle: assert property (ce && !(reg_rd && powered_up) |=> reg_rdata_ff == 16'h0000)
        else $error("read data not zero");
    chk_afc_tie: assert property (auto_freq_correction_ff == (reference_freq_value_ff != 16'h0000))
        else $error("afc out of step");
    chk_ref_write: assert property (acc && reg_wr && reg_addr == 16'h0201 && ref_ok
        |=> reference_freq_value_ff == $past(reg_wdata))
        else $error("reference value not taken");
endmodule

// file: verification/rpb_ctrl_model.sv
/* System controller model: register port, power state, reference.
 Assumes the bank samples on the rising clock edge. */
`timescale 1ns/1ps
module rpb_ctrl_model (
    // Clock
    input wire clk,
    // Register port
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    // Power state and reference
    output logic powered_up,
    output logic pwrup_cts_irq_en,
    output logic ext_reference
);
    // Idle at time zero; reference runs free, under the input limit
    initial begin
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        powered_up = 1'b0;
        pwrup_cts_irq_en = 1'b0;
        ext_reference = 1'b0;
        // Offset keeps reference edges away from clock edges
        #2;
        forever #15 ext_reference = ~ext_reference;
    end
    // Power changes only between accesses
    task power(input logic on, input logic cts);
        @(posedge clk);
        powered_up <= on;
        pwrup_cts_irq_en <= cts;
        @(posedge clk);
    endtask
    // Released lines show the inverse so stale values never match
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// file: verification/test_rpb_bank.sv
/* Bench for the property bank: controller model drives the port,
 events and service come from here. Assumes the constants header. */
`timescale 1ns/1ps
`include "rpb_consts.vh"
module test_rpb_bank;
    logic clk, rst, ce, ack, rd_d_ff;
    logic [3:0] evt;
    wire ws, rs, pw, pc, ext, pin, edg, mono, aen, afc, iref;
    wire [15:0] ad, wd, rdata, rate, refv;
    wire [4:0] fl, wbits;
    wire [3:0] mode;
    integer failures, n_compared, ticks;
    logic [15:0] exp_q[$];
    logic [15:0] v, x, lo, hi, a;
    logic [15:0] tv[6];
    int enb[4] = '{0, 2, 3, 6};
    int repb[3] = '{8, 10, 11};
    int mtab[4] = '{0, 6, 8, 12};
    int btab[4] = '{16, 20, 24, 8};

    rpb_bank u_rpb_bank (.clk(clk), .rst(rst), .ce(ce), .reg_addr(ad), .reg_wdata(wd), .reg_wr(ws),
        .reg_rd(rs), .reg_rdata_ff(rdata), .powered_up(pw), .pwrup_cts_irq_en(pc), .seek_tune_evt(evt[0]),
        .radio_data_evt(evt[1]), .signal_quality_evt(evt[2]), .fault_evt(evt[3]), .status_ack(ack),
        .seek_tune_done_flag(fl[0]), .radio_data_flag(fl[1]), .signal_quality_flag(fl[2]),
        .fault_flag(fl[3]), .clear_to_send_flag(fl[4]), .shared_interrupt_pin_ff(pin),
        .out_edge_select_ff(edg), .out_framing_mode_ff(mode), .force_single_channel_ff(mono),
        .out_word_bits_ff(wbits), .out_sample_rate_ff(rate), .audio_out_en_ff(aen), .ext_reference(ext),
        .reference_freq_value_ff(refv), .auto_freq_correction_ff(afc), .internal_reference_ff(iref));
    rpb_ctrl_model u_rpb_ctrl_model (.clk(clk), .reg_addr(ad), .reg_wdata(wd), .reg_wr(ws), .reg_rd(rs),
        .powered_up(pw), .pwrup_cts_irq_en(pc), .ext_reference(ext));

    task summarize;
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One cycle of events and/or service
    task pulse(input logic [3:0] m, input logic s);
        @(posedge clk);
        evt <= m;
        ack <= s;
        @(posedge clk);
        evt <= 4'h0;
        ack <= 1'b0;
        #1;
    endtask
    task wr(input logic [15:0] d_a, input logic [15:0] d);
        u_rpb_ctrl_model.wr(d_a, d);
        #1;
    endtask
    task rd(input logic [15:0] d_a, input logic [15:0] e);
        exp_q.push_back(e);
        u_rpb_ctrl_model.rd(d_a);
        #1;
    endtask

    // Read data is due only in the cycle after a strobe
    always @(posedge clk) rd_d_ff <= rs;
    always @(negedge clk) begin
        if (rd_d_ff)
            chk("read data", exp_q.pop_front(), rdata);
        if (iref)
            ticks++;
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, well past the expected run
    initial begin
        #400000;
        failures++;
        summarize;
    end

    initial begin
        void'($urandom(72144));
        rst = 1'b1;
        ce = 1'b1;
        ack = 1'b0;
        evt = 4'h0;
        failures = 0;
        n_compared = 0;
        ticks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped read
        u_rpb_ctrl_model.power(1'b1, 1'b0);
        cyc(2);
        rd(`RPB_ADDR_IEN, 16'h0000);
        rd(`RPB_ADDR_FMT, 16'h0000);
        rd(`RPB_ADDR_RATE, 16'h0000);
        rd(`RPB_ADDR_REF, 16'h8000);
        rd(16'h0003, 16'h0000);
        // Power-up enable, masking, clear-to-send interrupt
        u_rpb_ctrl_model.power(1'b0, 1'b0);
        u_rpb_ctrl_model.power(1'b1, 1'b1);
        cyc(2);
        chk("cts flag", 16'h0001, fl[4]);
        rd(`RPB_ADDR_IEN, 16'h0080);
        wr(`RPB_ADDR_IEN, 16'hffff);
        rd(`RPB_ADDR_IEN, 16'h0dcd);
        wr(`RPB_ADDR_IEN, 16'h0000);
        pulse(4'h0, 1'b1);
        chk("pin", 16'h0000, pin);
        wr(`RPB_ADDR_IEN, 16'h0080);
        cyc(2);
        chk("cts pin", 16'h0001, pin);
        wr(`RPB_ADDR_IEN, 16'h0000);
        pulse(4'h0, 1'b1);
        // Every framing code and precision; edge and mono random
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                x = $urandom;
                v = {8'h00, x[0], mtab[m][3:0], x[1], p[1:0]};
                wr(`RPB_ADDR_FMT, v);
                chk("edge", x[0], edg);
                chk("mode", mtab[m], mode);
                chk("mono", x[1], mono);
                chk("bits", btab[p], wbits);
            end
        end
        wr(`RPB_ADDR_FMT, 16'h0018);
        chk("mode kept", 16'h000c, mode);
        // Range edges; refused values keep the old one
        for (int k = 0; k < 2; k++) begin
            a = k ? `RPB_ADDR_REF : `RPB_ADDR_RATE;
            lo = k ? 16'h799a : 16'h7d00;
            hi = k ? 16'h8666 : 16'hbb80;
            x = k ? 16'h8000 : 16'h0000;
            tv = '{lo, hi, hi + 16'h1, lo - 16'h1, 16'h0, lo + 16'($urandom_range(hi - lo))};
            foreach (tv[j]) begin
                pulse(4'h0, 1'b1);
                wr(a, tv[j]);
                if (tv[j] == 0 || (tv[j] >= lo && tv[j] <= hi))
                    x = tv[j];
                chk("value", x, k ? refv : rate);
                chk("enable", x != 0, k ? afc : aen);
                chk("refused", x != tv[j], fl[3]);
            end
        end
        // Each event source: off, on, no repeat under service; repeat for all but fault
        for (int i = 0; i < 4; i++) begin
            wr(`RPB_ADDR_IEN, 16'h0000);
            pulse(4'h0, 1'b1);
            pulse(4'h1 << i, 1'b0);
            chk("flag", 16'h0001, fl[i]);
            cyc(1);
            chk("pin off", 16'h0000, pin);
            pulse(4'h0, 1'b1);
            chk("flag clear", 16'h0000, fl[i]);
            v = 16'h0001 << enb[i];
            wr(`RPB_ADDR_IEN, v);
            pulse(4'h1 << i, 1'b0);
            chk("pin early", 16'h0000, pin);
            cyc(4);
            chk("pin held", 16'h0001, pin);
            pulse(4'h1 << i, 1'b1);
            cyc(1);
            chk("no repeat", 16'h0000, pin);
            chk("flag kept", 16'h0001, fl[i]);
            if (i < 3) begin
                wr(`RPB_ADDR_IEN, v | (16'h0001 << repb[i]));
                pulse(4'h1 << i, 1'b0);
                cyc(1);
                chk("repeat", 16'h0001, pin);
            end
        end
        // Divider tick rate and refused zero
        wr(`RPB_ADDR_DIV, 16'h0003);
        ticks = 0;
        cyc(300);
        chk("ticks", 16'h0001, ticks >= 32 && ticks <= 34);
        wr(`RPB_ADDR_DIV, 16'h0000);
        rd(`RPB_ADDR_DIV, 16'h0003);
        // Powered down: refused
        pulse(4'h0, 1'b1);
        // Frozen clock enable: an event is not taken
        @(posedge clk) ce <= 1'b0;
        pulse(4'h1, 1'b0);
        chk("frozen flag", 16'h0000, fl[0]);
        @(posedge clk) ce <= 1'b1;
        u_rpb_ctrl_model.power(1'b0, 1'b0);
        wr(`RPB_ADDR_RATE, 16'h7d00);
        rd(`RPB_ADDR_RATE, 16'h0000);
        chk("down fault", 16'h0001, fl[3]);
        cyc(4);
        summarize;
    end
endmodule

bind rpb_bank rpb_bank_asserts u_rpb_bank_asserts (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .powered_up(powered_up), .seek_tune_evt(seek_tune_evt), .status_ack(status_ack),
    .clear_to_send_flag(clear_to_send_flag), .fault_flag(fault_flag), .radio_data_flag(radio_data_flag),
    .signal_quality_flag(signal_quality_flag), .seek_tune_done_flag(seek_tune_done_flag),
    .shared_interrupt_pin_ff(shared_interrupt_pin_ff), .reference_freq_value_ff(reference_freq_value_ff),
    .auto_freq_correction_ff(auto_freq_correction_ff));
